// >>> i2cms_defs.svh
`ifndef I2CMS_DEFS_SVH
`define I2CMS_DEFS_SVH
// port mode-select encodings
`define I2CMS_MODE_W 4
`define I2CMS_MODE_MASTER 4'h8
`define I2CMS_MODE_FWMASTER 4'hB
// baud generator reload width and reset reload
`define I2CMS_BRG_W 8
`define I2CMS_BRG_RST 8'h00
// transmit buffer geometry
`define I2CMS_FIFO_DEPTH 4
`define I2CMS_DATA_W 8
// bit positions within a byte transfer
`define I2CMS_LAST_DATA_BIT 4'h7
`define I2CMS_ACK_BIT 4'h8
// condition step counts (last step index)
`define I2CMS_START_LAST 2'h1
`define I2CMS_RSTART_LAST 2'h3
`define I2CMS_STOP_LAST 2'h2
`endif

// >>> i2cms_pkg.sv
package i2cms_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_START = 6'b00_0010,
    ST_RSTART = 6'b00_0100,
    ST_XFER = 6'b00_1000,
    ST_HOLD = 6'b01_0000,
    ST_STOP = 6'b10_0000
  } i2cms_state_type;

  // one sample of the two bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cms_lines_type;

  // one-cycle command strobes from software
  typedef struct packed {
    logic start;
    logic rstart;
    logic stop;
    logic rcv;
  } i2cms_cmd_type;
endpackage

// >>> i2cms_fifo.sv
`timescale 1ns/10ps
`include "i2cms_defs.svh"
module i2cms_fifo import i2cms_pkg::*; #(
  parameter int W = `I2CMS_DATA_W,
  parameter int D = `I2CMS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q;
  wire push = in_valid && ready_q;
  wire pop = out_valid && out_ready;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // ready is registered so the block's ready port comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      if (push) wr_q <= wrap_inc(wr_q);
      if (pop) rd_q <= wrap_inc(rd_q);
      cnt_q <= cnt_d;
      ready_q <= (cnt_d < (AW+1)'(D));
    end
  end
endmodule

// >>> i2cms_master.sv
`timescale 1ns/10ps
`include "i2cms_defs.svh"
module i2cms_master import i2cms_pkg::*; #(
  parameter int BRG_W = `I2CMS_BRG_W,
  parameter int FIFO_DEPTH = `I2CMS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [`I2CMS_MODE_W-1:0] port_mode_select,
  input wire logic port_enable_bit,
  input wire logic [BRG_W-1:0] brg_reload,
  input wire logic [6:0] target_addr,
  input wire logic read_dir,
  input wire logic ack_value,
  // commands
  input wire i2cms_cmd_type cmd,
  input wire logic irq_clr,
  input wire logic write_collision_flag_clr,
  // firmware-controlled line pulls
  input wire logic fw_sda_low,
  input wire logic fw_scl_low,
  // transmit data into the shift buffer
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [`I2CMS_DATA_W-1:0] tx_data,
  // status
  output logic port_irq_flag,
  output logic write_collision_flag,
  output logic start_det,
  output logic stop_det,
  output logic busy,
  output logic ack_status,
  output logic [`I2CMS_DATA_W-1:0] rx_data,
  output logic rx_valid,
  // bus lines, output enable low while driving
  input wire i2cms_lines_type bus_in,
  output logic sda_o,
  output logic sda_oe_n,
  output logic scl_o,
  output logic scl_oe_n
);
  i2cms_state_type state_q, state_d;
  i2cms_lines_type lines_q;
  logic [BRG_W-1:0] brg_q;
  logic [1:0] step_q;
  logic [3:0] bit_q;
  logic half_q, rx_mode_q;
  logic [`I2CMS_DATA_W-1:0] shift_q;
  logic sda_low_q, scl_low_q, sda_oe_n_q, scl_oe_n_q;
  logic irq_q, write_collision_flag_q, sdet_q, pdet_q, ack_q, rxv_q, busy_q;
  logic [`I2CMS_DATA_W-1:0] rxd_q;
  logic fifo_valid, fifo_pop;
  logic [`I2CMS_DATA_W-1:0] fifo_data;

  // mode decode
  wire port_on = port_enable_bit;
  wire master_en = port_on && (port_mode_select == `I2CMS_MODE_MASTER);
  wire fw_en = port_on && (port_mode_select == `I2CMS_MODE_FWMASTER);

  // baud generator: one-cycle tick paces every bus step
  wire brg_run = master_en && (state_q != ST_IDLE || cmd.start);
  wire tick = brg_run && (brg_q == '0);

  // condition detection on the sampled lines
  wire start_edge = lines_q.scl && bus_in.scl && lines_q.sda && !bus_in.sda;
  wire stop_edge = lines_q.scl && bus_in.scl && !lines_q.sda && bus_in.sda;

  // a transmit write while a start is still being generated is dropped
  wire start_busy = master_en && (state_q == ST_START || state_q == ST_RSTART);
  wire tx_take = tx_valid && tx_ready;
  wire collide = tx_take && start_busy;
  wire fifo_push = tx_valid && !start_busy;

  // step completion strobes
  wire start_done = tick && state_q == ST_START && step_q == `I2CMS_START_LAST;
  wire rstart_done = tick && state_q == ST_RSTART && step_q == `I2CMS_RSTART_LAST;
  wire stop_done = tick && state_q == ST_STOP && step_q == `I2CMS_STOP_LAST;
  wire sample = tick && state_q == ST_XFER && half_q;
  wire byte_done = sample && bit_q == `I2CMS_LAST_DATA_BIT;
  wire ack_done = sample && bit_q == `I2CMS_ACK_BIT;
  wire hold_tx = state_q == ST_HOLD && fifo_valid && !cmd.rstart && !cmd.stop;
  wire hold_rx = state_q == ST_HOLD && cmd.rcv && !fifo_valid && !cmd.rstart && !cmd.stop;
  assign fifo_pop = master_en && hold_tx;

  // detection raises irq only when not sequencing as master
  wire det_irq = fw_en && (start_edge || stop_edge);
  wire seq_irq = master_en && (start_done || rstart_done || stop_done || byte_done || ack_done);
  wire irq_ev = det_irq || seq_irq;

  // address byte with direction in the lsb
  wire [`I2CMS_DATA_W-1:0] addr_byte = {target_addr, read_dir};

  always_comb begin
    state_d = state_q;
    if (!master_en) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (cmd.start) state_d = ST_START;
        ST_START: if (start_done) state_d = ST_XFER;
        ST_RSTART: if (rstart_done) state_d = ST_XFER;
        ST_XFER: if (ack_done) state_d = ST_HOLD;
        ST_HOLD: begin
          if (cmd.stop) state_d = ST_STOP;
          else if (cmd.rstart) state_d = ST_RSTART;
          else if (hold_tx || hold_rx) state_d = ST_XFER;
        end
        ST_STOP: if (stop_done) state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      lines_q <= '1;
    end else begin
      state_q <= state_d;
      lines_q <= bus_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !brg_run || tick) begin
      brg_q <= (sys_rst || !brg_run) ? BRG_W'(`I2CMS_BRG_RST) : brg_reload;
    end else begin
      brg_q <= brg_q - 1'b1;
    end
  end

  // step counter for start, repeated start and stop
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_q != state_d) begin
      step_q <= 2'h0;
    end else if (tick) begin
      step_q <= step_q + 2'h1;
    end
  end

  // line pulls while sequencing; only ever low, never driven high
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !master_en) begin
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else if (tick) begin
      case (state_q)
        ST_START: begin
          if (step_q == 2'h0) sda_low_q <= 1'b1;
          else scl_low_q <= 1'b1;
        end
        ST_RSTART: begin
          if (step_q == 2'h0) sda_low_q <= 1'b0;
          else if (step_q == 2'h1) scl_low_q <= 1'b0;
          else if (step_q == 2'h2) sda_low_q <= 1'b1;
          else scl_low_q <= 1'b1;
        end
        ST_STOP: begin
          if (step_q == 2'h0) sda_low_q <= 1'b1;
          else if (step_q == 2'h1) scl_low_q <= 1'b0;
          else sda_low_q <= 1'b0;
        end
        ST_XFER: begin
          if (!half_q) begin
            if (bit_q == `I2CMS_ACK_BIT) sda_low_q <= rx_mode_q && !ack_value;
            else sda_low_q <= !rx_mode_q && !shift_q[7];
            scl_low_q <= 1'b0;
          end else begin
            scl_low_q <= 1'b1;
          end
        end
        default: begin
          sda_low_q <= sda_low_q;
          scl_low_q <= scl_low_q;
        end
      endcase
    end
  end

  // byte engine: low half sets data, high half samples
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !master_en) begin
      shift_q <= '0;
      bit_q <= 4'h0;
      half_q <= 1'b0;
      rx_mode_q <= 1'b0;
    end else if (start_done || rstart_done) begin
      shift_q <= addr_byte;
      bit_q <= 4'h0;
      half_q <= 1'b0;
      rx_mode_q <= 1'b0;
    end else if (state_d == ST_XFER && state_q == ST_HOLD) begin
      shift_q <= hold_tx ? fifo_data : '0;
      bit_q <= 4'h0;
      half_q <= 1'b0;
      rx_mode_q <= hold_rx;
    end else if (tick && state_q == ST_XFER) begin
      half_q <= !half_q;
      if (half_q) begin
        bit_q <= bit_q + 4'h1;
        if (bit_q != `I2CMS_ACK_BIT) shift_q <= {shift_q[6:0], bus_in.sda};
      end
    end
  end

  // pins: firmware mode hands the pulls to software
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
    end else if (fw_en) begin
      sda_oe_n_q <= !fw_sda_low;
      scl_oe_n_q <= !fw_scl_low;
    end else begin
      sda_oe_n_q <= !(master_en && sda_low_q);
      scl_oe_n_q <= !(master_en && scl_low_q);
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
    end else begin
      irq_q <= irq_ev || (irq_q && !irq_clr);
      write_collision_flag_q <= collide || (write_collision_flag_q && !write_collision_flag_clr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !port_on) begin
      sdet_q <= 1'b0;
      pdet_q <= 1'b0;
    end else if (start_edge) begin
      sdet_q <= 1'b1;
      pdet_q <= 1'b0;
    end else if (stop_edge) begin
      sdet_q <= 1'b0;
      pdet_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b1;
      rxd_q <= '0;
      rxv_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (ack_done && !rx_mode_q) ack_q <= bus_in.sda;
      if (byte_done && rx_mode_q) rxd_q <= {shift_q[6:0], bus_in.sda};
      rxv_q <= byte_done && rx_mode_q;
      busy_q <= state_d != ST_IDLE;
    end
  end

  // transmit buffer; it drains only as bytes go out, so a slow bus fills it
  i2cms_fifo #(
    .W(`I2CMS_DATA_W),
    .D(FIFO_DEPTH)
  ) u_txbuf (
    .clk(sys_clk),
    .rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign port_irq_flag = irq_q;
  assign write_collision_flag = write_collision_flag_q;
  assign start_det = sdet_q;
  assign stop_det = pdet_q;
  assign busy = busy_q;
  assign ack_status = ack_q;
  assign rx_data = rxd_q;
  assign rx_valid = rxv_q;
  assign sda_oe_n = sda_oe_n_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence start_seq;
    state_q == ST_START ##1 state_q == ST_XFER;
  endsequence

  sequence collide_seq;
    tx_valid && tx_ready && start_busy;
  endsequence

  write_collision_flag_set_a: assert property (collide_seq |=> write_collision_flag_q)
    else $error("collision did not set flag");
  write_collision_flag_drop_a: assert property (collide_seq |-> !fifo_push)
    else $error("colliding write entered buffer");
  det_clear_a: assert property (!port_enable_bit |=> !start_det && !stop_det)
    else $error("detect flags not cleared while disabled");
  low_only_a: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("line driven high");
  mode_gate_a: assert property (!master_en |=> state_q == ST_IDLE &&
    scl_oe_n_q == !($past(fw_en) && $past(fw_scl_low)))
    else $error("sequencer active outside master mode");
  fw_pass_a: assert property (fw_en |=> sda_oe_n == !$past(fw_sda_low))
    else $error("firmware pull not passed to pin");
  det_mask_a: assert property (master_en && !seq_irq && !irq_clr |=> irq_q == $past(irq_q))
    else $error("irq changed without sequencer event");
  event_irq_a: assert property (seq_irq |=> irq_q)
    else $error("event did not raise irq");
  addr_load_a: assert property (start_seq |-> shift_q == $past(addr_byte))
    else $error("address byte not loaded after start");
  brg_pace_a: assert property (master_en && $past(master_en) && $changed(scl_low_q) |-> $past(tick))
    else $error("clock edge not paced by baud tick");
  bit_span_a: assert property (state_q == ST_XFER |-> bit_q <= `I2CMS_ACK_BIT)
    else $error("byte ran past acknowledge bit");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("receive strobe held past one cycle");
  irq_hold_a: assert property (irq_q && !irq_clr |=> irq_q)
    else $error("irq dropped without a clear");
endmodule

// >>> i2cms_slave_model.sv
`timescale 1ns/10ps
module i2cms_slave_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // resolved lines and own pull on data
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  // behaviour chosen by the bench
  input wire logic ack_en,
  input wire logic [7:0] rd_byte,
  // what was seen on the bus
  output logic [7:0] addr_byte,
  output logic [7:0] data_byte,
  output logic master_ack,
  output int n_data,
  output int n_start,
  output int n_stop
);
  logic scl_q, sda_q, act, is_addr, rd_mode, sending;
  logic [3:0] cnt;
  logic [7:0] sh;
  // no clock stretching: the master paces every bit, so a reload of 0 is too fast for this model
  always @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (sys_rst) begin
      act <= 1'h0;
      sending <= 1'h0;
      sda_oe_n <= 1'h1;
      n_data <= 0;
      n_start <= 0;
      n_stop <= 0;
    end else if (scl && scl_q && sda_q && !sda) begin
      act <= 1'h1;
      is_addr <= 1'h1;
      rd_mode <= 1'h0;
      sending <= 1'h0;
      cnt <= 4'h0;
      sda_oe_n <= 1'h1;
      n_start <= n_start + 1;
    end else if (scl && scl_q && !sda_q && sda) begin
      act <= 1'h0;
      sda_oe_n <= 1'h1;
      n_stop <= n_stop + 1;
    end else if (act && scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
      if (cnt == 4'h7 && is_addr) begin
        addr_byte <= {sh[6:0], sda};
        rd_mode <= sda;
      end
      if (cnt == 4'h7 && !is_addr && !rd_mode) begin
        data_byte <= {sh[6:0], sda};
        n_data <= n_data + 1;
      end
      if (cnt == 4'h8) begin
        master_ack <= sda;
      end
    end else if (act && !scl && scl_q) begin
      // after a nack from the master the line is let go so that a stop can follow
      if (cnt == 4'h8) begin
        sda_oe_n <= !(ack_en && (is_addr || !rd_mode));
      end else if (cnt == 4'h9) begin
        cnt <= 4'h0;
        is_addr <= 1'h0;
        sending <= rd_mode && (is_addr ? ack_en : !master_ack);
        sda_oe_n <= !(rd_mode && (is_addr ? ack_en : !master_ack)) || rd_byte[7];
      end else if (sending && cnt != 4'h0 && cnt < 4'h8) begin
        sda_oe_n <= rd_byte[3'h7 - cnt[2:0]];
      end else begin
        sda_oe_n <= 1'h1;
      end
    end
  end
endmodule

// >>> i2c_master_sequencer_bench.sv
`timescale 1ns/10ps
`include "i2cms_defs.svh"
module i2c_master_sequencer_bench import i2cms_pkg::*; ;
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
    logic ack;
    logic [7:0] brg;
    logic [7:0] exp_addr;
    logic exp_nack;
  } i2cms_row_type;
  // direction, address, data, slave ack, reload, then expected address byte and ack status
  i2cms_row_type rows [5] = '{
    '{1'h0, 7'h50, 8'hA5, 1'h1, 8'h02, 8'hA0, 1'h0},
    '{1'h0, 7'h7F, 8'h00, 1'h0, 8'h03, 8'hFE, 1'h1},
    '{1'h1, 7'h01, 8'h3C, 1'h1, 8'h02, 8'h03, 1'h0},
    '{1'h1, 7'h2A, 8'hC6, 1'h1, 8'h05, 8'h55, 1'h0},
    '{1'h0, 7'h00, 8'h5A, 1'h1, 8'h07, 8'h00, 1'h0}};
  logic sys_clk, sys_rst, port_enable_bit, read_dir, ack_value, irq_clr, write_collision_flag_clr, fw_sda_low, fw_scl_low;
  logic [3:0] port_mode_select;
  logic [7:0] brg_reload, tx_data, rx_data, rd_byte, s_addr, s_data;
  logic [6:0] target_addr;
  i2cms_cmd_type cmd;
  i2cms_lines_type bus_in;
  logic tx_valid, tx_ready, port_irq_flag, write_collision_flag, start_det, stop_det, busy, ack_status, rx_valid;
  logic sda_o, sda_oe_n, scl_o, scl_oe_n, s_oe_n, ack_en, s_mack, scl_p;
  int n_data, n_start, n_stop, bad_count, n_checks, per_cnt, scl_per, k, j, m, n;
  int n_rxv = 0;

  // pull-ups: a line is low only while some party pulls it
  assign bus_in = '{scl: scl_oe_n, sda: sda_oe_n & s_oe_n};

  i2cms_master u_i2cms_master (.sys_clk(sys_clk), .sys_rst(sys_rst), .port_mode_select(port_mode_select),
    .port_enable_bit(port_enable_bit), .brg_reload(brg_reload), .target_addr(target_addr), .read_dir(read_dir),
    .ack_value(ack_value), .cmd(cmd), .irq_clr(irq_clr), .write_collision_flag_clr(write_collision_flag_clr), .fw_sda_low(fw_sda_low),
    .fw_scl_low(fw_scl_low), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .port_irq_flag(port_irq_flag), .write_collision_flag(write_collision_flag), .start_det(start_det),
    .stop_det(stop_det), .busy(busy), .ack_status(ack_status), .rx_data(rx_data), .rx_valid(rx_valid),
    .bus_in(bus_in), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n));

  i2cms_slave_model u_i2cms_slave_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl(bus_in.scl),
    .sda(bus_in.sda), .sda_oe_n(s_oe_n), .ack_en(ack_en), .rd_byte(rd_byte), .addr_byte(s_addr),
    .data_byte(s_data), .master_ack(s_mack), .n_data(n_data), .n_start(n_start), .n_stop(n_stop));

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // cycles between two clock-line rises
  always @(posedge sys_clk) begin
    scl_p <= bus_in.scl;
    per_cnt <= (bus_in.scl && !scl_p) ? 1 : per_cnt + 1;
    if (bus_in.scl && !scl_p) begin
      scl_per <= per_cnt;
    end
    // counted per cycle, so a strobe held too long shows up as extra counts
    if (rx_valid === 1'h1) begin
      n_rxv <= n_rxv + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic pulse(input i2cms_cmd_type c);
    cmd = c;
    @(negedge sys_clk);
    cmd = 4'h0;
  endtask

  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'h1;
    @(negedge sys_clk);
    tx_valid = 1'h0;
  endtask

  task automatic wait_irq(input int cnt);
    int t;
    repeat (cnt) begin
      t = 0;
      while (port_irq_flag !== 1'h1 && t < 2000) begin
        @(negedge sys_clk);
        t++;
      end
      check(t < 2000, 1'h1);
      irq_clr = 1'h1;
      @(negedge sys_clk);
      irq_clr = 1'h0;
    end
  endtask

  task automatic stop_bus();
    pulse(4'h2);
    wait_irq(1);
    repeat (12) @(negedge sys_clk);
    check({busy, port_irq_flag, stop_det, sda_oe_n, scl_oe_n, sda_o, scl_o}, 7'h1C);
  endtask

  task automatic xfer(input i2cms_row_type r);
    int v;
    brg_reload = r.brg;
    // ack only where the slave's next bit is a one, so it lets go of data and the stop still forms
    ack_value = !r.data[7];
    target_addr = r.addr;
    read_dir = r.rd;
    ack_en = r.ack;
    rd_byte = r.data;
    pulse(4'h8);
    wait_irq(3);
    check(s_addr, r.exp_addr);
    check(ack_status, r.exp_nack);
    check(scl_per, 2 * (r.brg + 1));
    if (r.rd) begin
      v = n_rxv;
      pulse(4'h1);
      wait_irq(2);
      check(rx_data, r.data);
      check(s_mack, ack_value);
      check(n_rxv - v, 1);
    end else begin
      push(r.data);
      wait_irq(2);
      check(s_data, r.data);
    end
    stop_bus();
  endtask

  // a full run takes some 2,000 cycles; the limit of 40,000 cycles leaves ample room
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial begin
    {sys_rst, port_enable_bit, ack_value, ack_en} = 4'hF;
    {read_dir, irq_clr, write_collision_flag_clr, fw_sda_low, fw_scl_low, tx_valid} = 6'h00;
    port_mode_select = `I2CMS_MODE_MASTER;
    brg_reload = 8'h02;
    target_addr = 7'h00;
    tx_data = 8'h00;
    rd_byte = 8'h00;
    cmd = 4'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(negedge sys_clk);
    check({sda_oe_n, scl_oe_n}, 2'h3);
    sys_rst = 1'h0;
    @(negedge sys_clk);
    check({sda_oe_n, scl_oe_n, port_irq_flag, write_collision_flag, start_det, stop_det, ack_status, tx_ready},
      8'hC3);
    foreach (rows[i]) begin
      xfer(rows[i]);
    end
    for (int i = 0; i < 2; i++) begin
      port_mode_select = (i == 0) ? 4'h0 : `I2CMS_MODE_MASTER;
      port_enable_bit = (i == 0);
      pulse(4'h8);
      repeat (20) @(negedge sys_clk);
      check({busy, scl_oe_n, sda_oe_n}, 3'h3);
    end
    port_enable_bit = 1'h1;
    brg_reload = 8'h02;
    read_dir = 1'h0;
    // a byte written while the start is still running must be lost, not queued
    pulse(4'h8);
    push(8'hEE);
    @(negedge sys_clk);
    check(write_collision_flag, 1'h1);
    k = n_data;
    wait_irq(3);
    repeat (60) @(negedge sys_clk);
    check(n_data, k);
    check(write_collision_flag, 1'h1);
    write_collision_flag_clr = 1'h1;
    @(negedge sys_clk);
    write_collision_flag_clr = 1'h0;
    check(write_collision_flag, 1'h0);
    stop_bus();
    target_addr = 7'h33;
    pulse(4'h8);
    wait_irq(3);
    k = n_data;
    j = n_start;
    m = n_stop;
    n = 0;
    while (tx_ready === 1'h1 && n < 8) begin
      tx_valid = 1'h1;
      tx_data = 8'h10 + n;
      n++;
      @(negedge sys_clk);
    end
    tx_valid = 1'h0;
    check(n >= `I2CMS_FIFO_DEPTH && n < 8, 1'h1);
    wait_irq(2 * n);
    check(n_data - k, n);
    check(s_data, 8'h10 + n - 1);
    check(tx_ready, 1'h1);
    pulse(4'h4);
    wait_irq(3);
    check(n_start - j, 1);
    check(n_stop - m, 0);
    check(s_addr, 8'h66);
    stop_bus();
    port_mode_select = `I2CMS_MODE_FWMASTER;
    pulse(4'h8);
    repeat (20) @(negedge sys_clk);
    check(busy, 1'h0);
    fw_sda_low = 1'h1;
    repeat (6) @(negedge sys_clk);
    check({sda_oe_n, start_det, port_irq_flag}, 3'h3);
    repeat (20) @(negedge sys_clk);
    check(port_irq_flag, 1'h1);
    irq_clr = 1'h1;
    @(negedge sys_clk);
    irq_clr = 1'h0;
    fw_sda_low = 1'h0;
    repeat (6) @(negedge sys_clk);
    check({stop_det, port_irq_flag}, 2'h3);
    fw_scl_low = 1'h1;
    @(negedge sys_clk);
    check(scl_oe_n, 1'h0);
    fw_scl_low = 1'h0;
    port_enable_bit = 1'h0;
    repeat (3) @(negedge sys_clk);
    check({start_det, stop_det}, 2'h0);
    finish_test();
  end
endmodule
